// *** common/ccd_pkg.sv ***
// Shared constants, encodings and types for the call/clear/decrement execution block
package ccd_pkg;

  // Datapath widths
  localparam int CCD_INSTR_W = 14; // Instruction word width
  localparam int CCD_PC_W = 13; // Program counter width
  localparam int CCD_DATA_W = 8; // File register and working register width
  localparam int CCD_FADDR_W = 7; // File address width, 0 to 127
  localparam int CCD_TGT_W = 11; // Immediate call target width, 0 to 2047
  localparam int CCD_ADDR_W = 2; // Register port address width
  localparam int CCD_CNT_W = 8; // Retired instruction counter width

  // Instruction field positions
  localparam int CCD_DEST_BIT = 7; // Destination select: 0 working register, 1 file
  localparam int CCD_LATCH_HI = 4; // Upper pc_high_latch bit copied on a call
  localparam int CCD_LATCH_LO = 3; // Lower pc_high_latch bit copied on a call

  // Opcode masks and match values
  localparam logic [13:0] CCD_MASK_CALL = 14'h3800;
  localparam logic [13:0] CCD_CODE_CALL = 14'h2000;
  localparam logic [13:0] CCD_MASK_WDTC = 14'h3FFF;
  localparam logic [13:0] CCD_CODE_WDTC = 14'h0064;
  localparam logic [13:0] CCD_MASK_ZFILE = 14'h3F80;
  localparam logic [13:0] CCD_CODE_ZFILE = 14'h0180;
  localparam logic [13:0] CCD_MASK_ZWORK = 14'h3F80;
  localparam logic [13:0] CCD_CODE_ZWORK = 14'h0100;
  localparam logic [13:0] CCD_MASK_FOP = 14'h3F00;
  localparam logic [13:0] CCD_CODE_INV = 14'h0900;
  localparam logic [13:0] CCD_CODE_DEC = 14'h0300;
  localparam logic [13:0] CCD_CODE_DSZ = 14'h0B00;

  // Register port offsets
  localparam logic [1:0] CCD_REG_CTRL = 2'h0; // Control: bit 0 enables execution
  localparam logic [1:0] CCD_REG_WORK = 2'h1; // Working register
  localparam logic [1:0] CCD_REG_STAT = 2'h2; // Status flags
  localparam logic [1:0] CCD_REG_CNT = 2'h3; // Retired instruction count, read only

  // Field positions and reset values
  localparam int CCD_CTRL_EN_BIT = 0;
  localparam int CCD_STAT_Z_BIT = 2;
  localparam int CCD_STAT_PWRDN_BIT = 3;
  localparam int CCD_STAT_TMOUT_BIT = 4;
  localparam logic CCD_CTRL_EN_RST = 1'h0;
  localparam logic [7:0] CCD_WORK_RST = 8'h00;
  localparam logic CCD_FLAG_Z_RST = 1'h0;
  localparam logic CCD_FLAG_TMOUT_RST = 1'h1;
  localparam logic CCD_FLAG_PWRDN_RST = 1'h1;
  localparam logic [7:0] CCD_ZERO_BYTE = 8'h00; // Value written by the clear operations

  // Decoded operation
  typedef enum logic [2:0] {
    CCD_OP_NONE = 3'h0,
    CCD_OP_CALL = 3'h1,
    CCD_OP_WDTC = 3'h2,
    CCD_OP_ZFILE = 3'h3,
    CCD_OP_ZWORK = 3'h4,
    CCD_OP_INV = 3'h5,
    CCD_OP_DEC = 3'h6,
    CCD_OP_DSZ = 3'h7
  } ccd_op_type;

  // Execution sequencer states, one-hot
  typedef enum logic [1:0] {
    CCD_ST_EXEC = 2'b01,
    CCD_ST_FLUSH = 2'b10
  } ccd_state_type;

  // Masked opcode compare, used for every pattern
  function automatic logic ccd_match(input logic [13:0] instr, input logic [13:0] mask,
                                     input logic [13:0] code);
    ccd_match = ((instr & mask) == code);
  endfunction

endpackage

// *** verilog/ccd_decode.sv ***
// Instruction pattern decoder for the covered operations
module ccd_decode
  import ccd_pkg::*;
(
  input wire logic [CCD_INSTR_W-1:0] i_instr,
  output ccd_op_type o_op
);

  // Patterns do not overlap, so the order only matters for readability
  always_comb begin
    if (ccd_match(i_instr, CCD_MASK_CALL, CCD_CODE_CALL)) begin
      o_op = CCD_OP_CALL;
    end else if (ccd_match(i_instr, CCD_MASK_WDTC, CCD_CODE_WDTC)) begin
      o_op = CCD_OP_WDTC;
    end else if (ccd_match(i_instr, CCD_MASK_ZFILE, CCD_CODE_ZFILE)) begin
      o_op = CCD_OP_ZFILE;
    end else if (ccd_match(i_instr, CCD_MASK_ZWORK, CCD_CODE_ZWORK)) begin
      o_op = CCD_OP_ZWORK;
    end else if (ccd_match(i_instr, CCD_MASK_FOP, CCD_CODE_INV)) begin
      o_op = CCD_OP_INV;
    end else if (ccd_match(i_instr, CCD_MASK_FOP, CCD_CODE_DEC)) begin
      o_op = CCD_OP_DEC;
    end else if (ccd_match(i_instr, CCD_MASK_FOP, CCD_CODE_DSZ)) begin
      o_op = CCD_OP_DSZ;
    end else begin
      // Anything else belongs to other execution units
      o_op = CCD_OP_NONE;
    end
  end

endmodule

// *** verilog/ccd_alu.sv ***
// Result and zero computation for clear, complement and decrement
module ccd_alu
  import ccd_pkg::*;
#(
  parameter int DATA_W = CCD_DATA_W
)
(
  input ccd_op_type i_op,
  input wire logic [DATA_W-1:0] i_operand,
  output logic [DATA_W-1:0] o_result,
  output logic o_zero
);

  // Result by operation; unused operations give zero
  always_comb begin
    unique case (i_op)
      CCD_OP_INV: o_result = ~i_operand;
      CCD_OP_DEC, CCD_OP_DSZ: o_result = i_operand - DATA_W'(1);
      default: o_result = '0;
    endcase
  end

  // Zero detect on the result
  assign o_zero = (o_result == '0);

endmodule

// *** verilog/ccd_exec.sv ***
// Execution unit for call, watchdog clear, clear, complement and decrement operations
//
// Added by the designer: the address-and-strobe port and the address map.
module ccd_exec
  import ccd_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_instr_valid,
  input wire logic [CCD_INSTR_W-1:0] i_instr,
  input wire logic [CCD_PC_W-1:0] i_pc,
  input wire logic [CCD_DATA_W-1:0] i_pc_high_latch,
  input wire logic [CCD_DATA_W-1:0] i_file_rdata,
  input wire logic [CCD_ADDR_W-1:0] i_reg_addr,
  input wire logic [CCD_DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic o_instr_ready,
  output logic [CCD_FADDR_W-1:0] o_file_raddr,
  output logic o_file_we,
  output logic [CCD_FADDR_W-1:0] o_file_waddr,
  output logic [CCD_DATA_W-1:0] o_file_wdata,
  output logic o_pc_load,
  output logic [CCD_PC_W-1:0] o_pc_target,
  output logic o_stack_push,
  output logic [CCD_PC_W-1:0] o_stack_data,
  output logic o_wdt_clear,
  output logic o_prescaler_clear,
  output logic o_skip,
  output logic [CCD_DATA_W-1:0] o_work,
  output logic o_zero_flag,
  output logic o_timeout_flag,
  output logic o_powerdown_flag,
  output logic [CCD_DATA_W-1:0] o_reg_rdata
);

  // Sequencer state
  ccd_state_type state_reg; // Current sequencer state
  ccd_state_type state_next; // Next sequencer state

  // Decode and datapath
  ccd_op_type op; // Decoded operation of the offered word
  logic [CCD_DATA_W-1:0] alu_result; // Result for clear, complement and decrement
  logic alu_zero; // Result is zero
  logic take; // Instruction accepted at this edge
  logic dest_file; // Destination bit selects the file register
  logic writes_work; // Result lands in the working register
  logic writes_file; // Result lands in a file register
  logic sets_zero; // Operation updates the zero flag
  logic skip_now; // Decrement-skip produced zero

  // Software visible state
  logic ctrl_en_reg; // Execution enable from the control register
  logic [CCD_DATA_W-1:0] work_reg; // Working register
  logic zero_reg; // Zero flag
  logic timeout_reg; // Timeout flag, high means no timeout seen
  logic powerdown_reg; // Powerdown flag, high means not asleep
  logic [CCD_CNT_W-1:0] retired_reg; // Count of accepted instructions that decode to a covered operation
  logic sw_wr_work; // Software writes the working register
  logic sw_wr_stat; // Software writes the status register

  // Decoder and arithmetic
  ccd_decode u_decode (
    .i_instr(i_instr),
    .o_op(op)
  );

  ccd_alu #(
    .DATA_W(CCD_DATA_W)
  ) u_alu (
    .i_op(op),
    .i_operand(i_file_rdata),
    .o_result(alu_result),
    .o_zero(alu_zero)
  );

  // Handshake: only accept in the execute state while software has enabled the unit
  assign o_instr_ready = (state_reg == CCD_ST_EXEC) && ctrl_en_reg;
  assign take = i_ce && i_instr_valid && o_instr_ready;

  // File address comes straight from the word so the register file can answer in the same cycle
  assign o_file_raddr = i_instr[CCD_FADDR_W-1:0];

  // Software strokes, gated by the clock enable like everything else
  assign sw_wr_work = i_ce && i_reg_wr && (i_reg_addr == CCD_REG_WORK);
  assign sw_wr_stat = i_ce && i_reg_wr && (i_reg_addr == CCD_REG_STAT);

  // Destination routing by operation and destination bit
  always_comb begin
    dest_file = i_instr[CCD_DEST_BIT];
    writes_work = 1'b0;
    writes_file = 1'b0;
    sets_zero = 1'b0;
    unique case (op)
      CCD_OP_ZFILE: begin
        writes_file = 1'b1;
        sets_zero = 1'b1;
      end
      CCD_OP_ZWORK: begin
        writes_work = 1'b1;
        sets_zero = 1'b1;
      end
      CCD_OP_INV, CCD_OP_DEC: begin
        writes_work = !dest_file;
        writes_file = dest_file;
        sets_zero = 1'b1;
      end
      CCD_OP_DSZ: begin
        // Same routing as a plain decrement, but the flags stay put
        writes_work = !dest_file;
        writes_file = dest_file;
        sets_zero = 1'b0;
      end
      default: begin
        // Call, watchdog clear and foreign words touch no data destination
        sets_zero = 1'b0;
      end
    endcase
  end

  assign skip_now = (op == CCD_OP_DSZ) && alu_zero;

  // Next state: a call or a zero decrement-skip spends one extra cycle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CCD_ST_EXEC: begin
        if (take && ((op == CCD_OP_CALL) || skip_now)) begin
          state_next = CCD_ST_FLUSH;
        end
      end
      CCD_ST_FLUSH: begin
        // The fetched word behind us is dropped; a no-operation fills this slot
        state_next = CCD_ST_EXEC;
      end
      default: begin
        // Illegal one-hot code recovers to execute
        state_next = CCD_ST_EXEC;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_reg <= CCD_ST_EXEC;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  // Control register: enable bit
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ctrl_en_reg <= CCD_CTRL_EN_RST;
    end else if (i_ce && i_reg_wr && (i_reg_addr == CCD_REG_CTRL)) begin
      ctrl_en_reg <= i_reg_wdata[CCD_CTRL_EN_BIT];
    end
  end

  // Working register: an executing instruction wins over a software write
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      work_reg <= CCD_WORK_RST;
    end else if (take && writes_work) begin
      work_reg <= alu_result;
    end else if (sw_wr_work) begin
      work_reg <= i_reg_wdata;
    end
  end

  // Zero flag: updated by clear, complement and plain decrement, and by a software status write
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      zero_reg <= CCD_FLAG_Z_RST;
    end else if (take && sets_zero) begin
      zero_reg <= alu_zero;
    end else if (sw_wr_stat) begin
      zero_reg <= i_reg_wdata[CCD_STAT_Z_BIT];
    end
  end

  // Timeout and powerdown flags: the watchdog clear sets them and beats a software clear
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      timeout_reg <= CCD_FLAG_TMOUT_RST;
      powerdown_reg <= CCD_FLAG_PWRDN_RST;
    end else if (take && (op == CCD_OP_WDTC)) begin
      timeout_reg <= 1'b1;
      powerdown_reg <= 1'b1;
    end else if (sw_wr_stat) begin
      timeout_reg <= i_reg_wdata[CCD_STAT_TMOUT_BIT];
      powerdown_reg <= i_reg_wdata[CCD_STAT_PWRDN_BIT];
    end
  end

  // Program counter and stack strobes for a call
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_pc_load <= 1'b0;
      o_stack_push <= 1'b0;
      o_pc_target <= '0;
      o_stack_data <= '0;
    end else if (i_ce) begin
      o_pc_load <= take && (op == CCD_OP_CALL);
      o_stack_push <= take && (op == CCD_OP_CALL);
      if (take && (op == CCD_OP_CALL)) begin
        // Return address is the word after the call
        o_stack_data <= CCD_PC_W'(i_pc + CCD_PC_W'(1));
        o_pc_target <= {i_pc_high_latch[CCD_LATCH_HI:CCD_LATCH_LO], i_instr[CCD_TGT_W-1:0]};
      end
    end
  end

  // Watchdog strobes; the counter itself lives outside and clears on these
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_wdt_clear <= 1'b0;
      o_prescaler_clear <= 1'b0;
    end else if (i_ce) begin
      o_wdt_clear <= take && (op == CCD_OP_WDTC);
      o_prescaler_clear <= take && (op == CCD_OP_WDTC);
    end
  end

  // File register write port
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_file_we <= 1'b0;
      o_file_waddr <= '0;
      o_file_wdata <= '0;
    end else if (i_ce) begin
      o_file_we <= take && writes_file;
      if (take && writes_file) begin
        o_file_waddr <= i_instr[CCD_FADDR_W-1:0];
        o_file_wdata <= alu_result;
      end
    end
  end

  // Skip strobe tells fetch to discard the word already in flight
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_skip <= 1'b0;
    end else if (i_ce) begin
      o_skip <= take && skip_now;
    end
  end

  // Retired count; wraps, meant only as a liveness hint for software
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      retired_reg <= '0;
    end else if (take && (op != CCD_OP_NONE)) begin
      retired_reg <= retired_reg + CCD_CNT_W'(1);
    end
  end

  // Read data stand for exactly one cycle after the read strobe
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= '0;
    end else if (i_ce) begin
      o_reg_rdata <= '0;
      if (i_reg_rd) begin
        unique case (i_reg_addr)
          CCD_REG_CTRL: o_reg_rdata <= CCD_DATA_W'(ctrl_en_reg);
          CCD_REG_WORK: o_reg_rdata <= work_reg;
          CCD_REG_STAT: begin
            o_reg_rdata <= CCD_DATA_W'({timeout_reg, powerdown_reg, zero_reg}) << CCD_STAT_Z_BIT;
          end
          CCD_REG_CNT: o_reg_rdata <= retired_reg;
        endcase
      end
    end
  end

  // Flag and register outputs
  assign o_work = work_reg;
  assign o_zero_flag = zero_reg;
  assign o_timeout_flag = timeout_reg;
  assign o_powerdown_flag = powerdown_reg;

  // Checks on the execution results
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  call_push_a: assert property (
    take && (op == CCD_OP_CALL) |=> o_stack_push && o_stack_data == CCD_PC_W'($past(i_pc) + CCD_PC_W'(1))
  ) else $error("call did not push the return address");

  call_low_a: assert property (
    take && (op == CCD_OP_CALL) |=> o_pc_load && o_pc_target[10:0] == $past(i_instr[10:0])
  ) else $error("call target low bits wrong");

  call_high_a: assert property (
    take && (op == CCD_OP_CALL) |=> o_pc_target[12:11] == $past(i_pc_high_latch[4:3])
  ) else $error("call target high bits not from latch");

  call_two_cycle_a: assert property (
    take && (op == CCD_OP_CALL) |=> !o_instr_ready
  ) else $error("call accepted a word in its second cycle");

  wdt_clear_a: assert property (
    take && (op == CCD_OP_WDTC) |=> o_wdt_clear && o_prescaler_clear
  ) else $error("watchdog clear strobes missing");

  wdt_flags_a: assert property (
    take && (op == CCD_OP_WDTC) |=> o_timeout_flag && o_powerdown_flag
  ) else $error("watchdog clear did not set flags");

  clear_file_a: assert property (
    take && (op == CCD_OP_ZFILE) |=> o_file_we && o_file_wdata == 8'h00 && o_zero_flag
      && o_file_waddr == $past(i_instr[6:0])
  ) else $error("clear file wrong");

  clear_work_a: assert property (
    take && (op == CCD_OP_ZWORK) |=> o_work == 8'h00 && o_zero_flag && !o_file_we
  ) else $error("clear working register wrong");

  comp_route_a: assert property (
    take && (op == CCD_OP_INV) && !i_instr[7] |=> o_work == ~$past(i_file_rdata) && !o_file_we
  ) else $error("complement to working register wrong");

  dec_route_a: assert property (
    take && (op == CCD_OP_DEC) && i_instr[7]
      |=> o_file_we && o_file_wdata == $past(i_file_rdata) - 8'h01 && o_zero_flag == (o_file_wdata == 8'h00)
  ) else $error("decrement to file wrong");

  dsz_pass_a: assert property (
    take && (op == CCD_OP_DSZ) && (i_file_rdata != 8'h01) |=> !o_skip && (state_reg == CCD_ST_EXEC)
  ) else $error("decrement-skip skipped on nonzero");

  dsz_skip_a: assert property (
    take && (op == CCD_OP_DSZ) && (i_file_rdata == 8'h01) |=> o_skip && !o_instr_ready
  ) else $error("decrement-skip did not skip on zero");

  flag_keep_a: assert property (
    take && ((op == CCD_OP_CALL) || (op == CCD_OP_DSZ)) && !sw_wr_stat |=> $stable(o_zero_flag)
  ) else $error("zero flag changed by call or decrement-skip");

  call_seen_c: cover property (take && (op == CCD_OP_CALL) ##2 take);
  dsz_skip_c: cover property (take && (op == CCD_OP_DSZ) && (i_file_rdata == 8'h01));
  wdt_race_c: cover property (take && (op == CCD_OP_WDTC) && sw_wr_stat);
  inv_file_c: cover property (take && (op == CCD_OP_INV) && i_instr[7]);

endmodule

// *** verif/ccd_exec_tb.sv ***
// Self-checking testbench for the call, clear and decrement execution unit
module ccd_exec_tb
  import ccd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus, all driven from the bench
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_ce = 1'b1; // Low only inside the freeze scenario
  logic i_instr_valid = 1'b0;
  logic [CCD_INSTR_W-1:0] i_instr = '0;
  logic [CCD_PC_W-1:0] i_pc = '0;
  logic [CCD_DATA_W-1:0] i_pc_high_latch = '0;
  logic [CCD_DATA_W-1:0] i_file_rdata = '0; // Stands in for the file register read
  logic [CCD_ADDR_W-1:0] i_reg_addr = '0;
  logic [CCD_DATA_W-1:0] i_reg_wdata = '0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  // Observed outputs
  logic o_instr_ready, o_file_we, o_pc_load, o_stack_push, o_wdt_clear, o_prescaler_clear, o_skip;
  logic o_zero_flag, o_timeout_flag, o_powerdown_flag;
  logic [CCD_FADDR_W-1:0] o_file_raddr, o_file_waddr;
  logic [CCD_DATA_W-1:0] o_file_wdata, o_work, o_reg_rdata;
  logic [CCD_PC_W-1:0] o_pc_target, o_stack_data;
  // Bookkeeping
  int failures = 0;
  int n_compared = 0;
  int n_ops = 0; // Instructions expected in the retired count
  int cycles = 0;
  logic [7:0] rd;

  ccd_exec DUT (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_pc(i_pc), .i_pc_high_latch(i_pc_high_latch), .i_file_rdata(i_file_rdata),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_instr_ready(o_instr_ready), .o_file_raddr(o_file_raddr), .o_file_we(o_file_we),
    .o_file_waddr(o_file_waddr), .o_file_wdata(o_file_wdata), .o_pc_load(o_pc_load),
    .o_pc_target(o_pc_target), .o_stack_push(o_stack_push), .o_stack_data(o_stack_data),
    .o_wdt_clear(o_wdt_clear), .o_prescaler_clear(o_prescaler_clear), .o_skip(o_skip),
    .o_work(o_work), .o_zero_flag(o_zero_flag), .o_timeout_flag(o_timeout_flag),
    .o_powerdown_flag(o_powerdown_flag), .o_reg_rdata(o_reg_rdata)
  );

  // 100 MHz clock
  always #5 i_mclk = ~i_mclk;

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end

  // Value comparison, case equality so unknowns never match
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Strobe vector: file write, pc load, push, wdt clear, prescaler clear, skip, ready
  task automatic strb(input logic [6:0] exp);
    chk("strobes", exp, {o_file_we, o_pc_load, o_stack_push, o_wdt_clear, o_prescaler_clear, o_skip, o_instr_ready});
  endtask

  // Single-cycle register write
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
    #1;
  endtask

  // Single-cycle register read, data taken in the following cycle only
  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    #1;
    d = o_reg_rdata;
  endtask

  // Offer one instruction, hold it until taken, return one step into the answer cycle
  task automatic issue(input logic [13:0] ins, input logic [12:0] pc, input logic [7:0] lat, input logic [7:0] fd);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_instr_valid <= 1'b1;
    i_instr <= ins;
    i_pc <= pc;
    i_pc_high_latch <= lat;
    i_file_rdata <= fd;
    #1;
    // Ready comes only from registers, so a high seen now holds until the taking edge
    while (o_instr_ready !== 1'b1 && n < 8) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk("ready_wait", 16'h0001, {15'h0000, o_instr_ready});
    @(posedge i_mclk);
    i_instr_valid <= 1'b0;
    #1;
    n_ops++;
  endtask

  // Reset values, then enable execution
  task automatic t_reset();
    chk("work", 16'h0000, o_work);
    chk("flags", 16'h0003, {o_zero_flag, o_timeout_flag, o_powerdown_flag});
    strb(7'h00);
    reg_rd(CCD_REG_STAT, rd);
    chk("stat_read", 16'h0018, rd);
    @(posedge i_mclk);
    #1;
    chk("rdata_idle", 16'h0000, o_reg_rdata);
    reg_wr(CCD_REG_CTRL, 8'h01);
    strb(7'h01);
  endtask

  // Calls at both ends of the target range and both latch bit values
  task automatic t_call();
    reg_wr(CCD_REG_STAT, 8'h04); // Zero flag set so a stray update shows
    issue(CCD_CODE_CALL | 14'h07FF, 13'h0ABC, 8'h18, 8'h00);
    strb(7'h30);
    chk("pc_target", 16'h1FFF, o_pc_target);
    chk("stack_data", 16'h0ABD, o_stack_data);
    chk("zero", 16'h0001, o_zero_flag);
    @(posedge i_mclk);
    #1;
    strb(7'h01);
    issue(CCD_CODE_CALL, 13'h1FFE, 8'hE7, 8'h00);
    strb(7'h30);
    chk("pc_target", 16'h0000, o_pc_target);
    chk("stack_data", 16'h1FFF, o_stack_data);
  endtask

  // Watchdog clear pulses and status set from cleared flags
  task automatic t_wdt();
    reg_wr(CCD_REG_STAT, 8'h00);
    chk("flags", 16'h0000, {o_zero_flag, o_timeout_flag, o_powerdown_flag});
    issue(CCD_CODE_WDTC, 13'h0010, 8'h00, 8'h00);
    strb(7'h0D);
    chk("flags", 16'h0003, {o_zero_flag, o_timeout_flag, o_powerdown_flag});
  endtask

  // Clear of the top file address and of the working register
  task automatic t_clear();
    issue(CCD_CODE_ZFILE | 14'h007F, 13'h0011, 8'h00, 8'h55);
    strb(7'h41);
    chk("waddr", 16'h007F, o_file_waddr);
    chk("wdata", 16'h0000, o_file_wdata);
    chk("zero", 16'h0001, o_zero_flag);
    reg_wr(CCD_REG_WORK, 8'hA5);
    reg_wr(CCD_REG_STAT, 8'h00);
    issue(CCD_CODE_ZWORK, 13'h0012, 8'h00, 8'h77);
    strb(7'h01);
    chk("zero", 16'h0001, o_zero_flag);
    reg_rd(CCD_REG_WORK, rd);
    chk("work_read", 16'h0000, rd);
  endtask

  // Complement and decrement, both destinations, zero and wrap results
  task automatic t_fop();
    logic [7:0] fd [8] = '{8'hFF, 8'hFF, 8'h5A, 8'h5A, 8'h01, 8'h01, 8'h00, 8'h00};
    logic [7:0] ex [8] = '{8'h00, 8'h00, 8'hA5, 8'hA5, 8'h00, 8'h00, 8'hFF, 8'hFF};
    logic [13:0] op;
    for (int i = 0; i < 8; i++) begin
      op = (i < 4) ? CCD_CODE_INV : CCD_CODE_DEC;
      reg_wr(CCD_REG_WORK, 8'h3C);
      // Preset the zero flag opposite to the expected outcome
      reg_wr(CCD_REG_STAT, (ex[i] == 8'h00) ? 8'h00 : 8'h04);
      issue(op | (i[0] ? 14'h0080 : 14'h0000) | 14'h0021, 13'h0020, 8'h00, fd[i]);
      chk("raddr", 16'h0021, o_file_raddr);
      chk("zero", (ex[i] == 8'h00) ? 16'h0001 : 16'h0000, o_zero_flag);
      if (i[0]) begin
        strb(7'h41);
        chk("wdata", ex[i], o_file_wdata);
        chk("work", 16'h003C, o_work);
      end else begin
        strb(7'h01);
        chk("work", ex[i], o_work);
      end
    end
  endtask

  // Decrement with skip: zero results stall one cycle, flags never move
  task automatic t_dsz();
    logic [7:0] fd [4] = '{8'h01, 8'h01, 8'h10, 8'h00};
    logic [7:0] ex [4] = '{8'h00, 8'h00, 8'h0F, 8'hFF};
    logic sk;
    for (int i = 0; i < 4; i++) begin
      sk = (ex[i] == 8'h00);
      reg_wr(CCD_REG_WORK, 8'hC3);
      reg_wr(CCD_REG_STAT, sk ? 8'h00 : 8'h04);
      issue(CCD_CODE_DSZ | (i[0] ? 14'h0080 : 14'h0000) | 14'h0005, 13'h0030, 8'h00, fd[i]);
      strb({i[0], 4'h0, sk, ~sk});
      chk("zero", {15'h0000, ~sk}, o_zero_flag);
      if (i[0]) chk("wdata", ex[i], o_file_wdata);
      else chk("work", ex[i], o_work);
      if (sk) begin
        @(posedge i_mclk);
        #1;
        strb(7'h01);
      end
    end
  endtask

  // Unknown opcode does nothing; count register ignores writes
  task automatic t_misc();
    issue(14'h3FFF, 13'h0040, 8'h00, 8'h00);
    n_ops--; // Not a retired instruction
    strb(7'h01);
    reg_wr(CCD_REG_CNT, 8'h33);
    reg_rd(CCD_REG_CNT, rd);
    chk("count", n_ops[7:0], rd);
  endtask

  // Clock enable low freezes the unit: an offered clear must wait, nothing may move
  task automatic t_freeze();
    reg_wr(CCD_REG_WORK, 8'h5A);
    @(posedge i_mclk);
    i_ce <= 1'b0;
    i_instr_valid <= 1'b1;
    i_instr <= CCD_CODE_ZWORK;
    repeat (3) @(posedge i_mclk);
    i_instr_valid <= 1'b0;
    i_ce <= 1'b1;
    #1;
    chk("frozen_work", 16'h005A, o_work);
    strb(7'h01);
  endtask

  // Closing report
  task give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    #1;
    t_reset();
    t_call();
    t_wdt();
    t_clear();
    t_fop();
    t_dsz();
    t_misc();
    t_freeze();
    give_verdict();
  end
endmodule
